// >>> src/spcr_regs.vh
// Constants for the serial port configuration block of the clock generator.
// Assumes a host that drives chip select, serial clock and data in sync with sys_clk.
// Function
// - With the direction bit at 0 reads leave on the data pin and the separate output pin floats; at 1 reads leave on the output pin.
// - With bit order 0 data goes most significant bit first and the address steps down; at 1 least significant first and up.
// - Writing 1 to soft reset holds every other register at its default until the host writes the bit back to 0.
// - Reads return buffered values when the readback bit is 0 and active values when it is 1.
`ifndef SPCR_REGS_VH
`define SPCR_REGS_VH

// Register addresses
`define SPCR_ADDR_W          13
`define SPCR_ADDR_PORT_CFG   13'h0000
`define SPCR_ADDR_RB_SEL     13'h0004
`define SPCR_ADDR_PDS        13'h0230
`define SPCR_ADDR_RSVD       13'h0231
`define SPCR_ADDR_COMMIT     13'h0232

// Port configuration fields
`define SPCR_BIT_DIR         7
`define SPCR_BIT_LSB_FIRST   6
`define SPCR_BIT_SOFT_RST    5
`define SPCR_BIT_LONG_INSTR  4
`define SPCR_NIB_HI          7:4
`define SPCR_BIT_RB_ACTIVE   0
`define SPCR_BIT_COMMIT      0

// Reset values
`define SPCR_RST_PORT_CFG    8'h18
`define SPCR_RST_RB_SEL      8'h00
`define SPCR_RST_PDS         8'h00
`define SPCR_RST_ZERO        8'h00

// Instruction word fields
`define SPCR_INSTR_RW        15
`define SPCR_INSTR_LEN       14:13
`define SPCR_INSTR_ADDR      12:0
`define SPCR_LEN_STREAM      2'h3
`define SPCR_BIT_LAST        3'h7

`endif

// >>> src/spcr_serdes.v
// Bit-level shifter of the serial port: samples the host clock, assembles bytes, shifts read data out.
// Assumes the serial clock idles low and runs at no more than a quarter of sys_clk.
`timescale 1ns/1ps
`include "spcr_regs.vh"

module spcr_serdes (
    sys_clk,
    sys_rst,
    sclk,
    cs_n,
    din,
    lsb_first,
    tx_load,
    tx_byte,
    rx_byte,
    rx_done,
    dout
);
    input  wire       sys_clk;
    input  wire       sys_rst;
    input  wire       sclk;
    input  wire       cs_n;
    input  wire       din;
    input  wire       lsb_first;
    input  wire       tx_load;
    input  wire [7:0] tx_byte;
    output wire [7:0] rx_byte;
    output wire       rx_done;
    output wire       dout;

    reg        sclk_d_reg;
    reg  [2:0] bit_cnt_reg;
    reg  [7:0] rx_sr_reg;
    reg  [7:0] rx_byte_reg;
    reg        rx_done_reg;
    reg  [7:0] tx_sr_reg;
    reg        dout_reg;
    wire       rise;
    wire       fall;
    wire [7:0] rx_sr_next;

    // Edges of the serial clock inside a frame
    assign rise = sclk & ~sclk_d_reg & ~cs_n;
    assign fall = ~sclk & sclk_d_reg & ~cs_n;
    // Incoming bit lands at the end that matches the bit order
    assign rx_sr_next = lsb_first ? {din, rx_sr_reg[7:1]} : {rx_sr_reg[6:0], din};

    assign rx_byte = rx_byte_reg;
    assign rx_done = rx_done_reg;
    assign dout    = dout_reg;

    // Receive side: sample on rising edges, flag each full byte
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d_reg  <= 1'b0;
            bit_cnt_reg <= 3'h0;
            rx_sr_reg   <= `SPCR_RST_ZERO;
            rx_byte_reg <= `SPCR_RST_ZERO;
            rx_done_reg <= 1'b0;
        end else begin
            sclk_d_reg  <= sclk;
            rx_done_reg <= 1'b0;
            if (cs_n) begin
                bit_cnt_reg <= 3'h0;
            end else if (rise) begin
                rx_sr_reg   <= rx_sr_next;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == `SPCR_BIT_LAST) begin
                    rx_byte_reg <= rx_sr_next;
                    rx_done_reg <= 1'b1;
                end
            end
        end
    end

    // Transmit side: load a byte, present one bit per falling edge
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_sr_reg <= `SPCR_RST_ZERO;
            dout_reg  <= 1'b0;
        end else if (tx_load) begin
            tx_sr_reg <= tx_byte;
        end else if (fall) begin
            dout_reg  <= lsb_first ? tx_sr_reg[0] : tx_sr_reg[7];
            tx_sr_reg <= lsb_first ? {1'b0, tx_sr_reg[7:1]} : {tx_sr_reg[6:0], 1'b0};
        end
    end
endmodule

// >>> src/spcr_port.v
// Serial control port of the clock generator: instruction decode, configuration,
// readback selection, soft reset and buffered-to-active commit of settings.
// Assumes a host that follows the 16-bit instruction framing with chip select low
// for the whole transfer and inputs synchronous to sys_clk.
`timescale 1ns/1ps
`include "spcr_regs.vh"

module spcr_port (
    sys_clk,
    sys_rst,
    cs_n,
    sclk,
    sdio_in,
    sdio_out,
    sdio_oe_n,
    read_out_pin,
    read_out_oe_n,
    pds_active,
    soft_reset_active,
    lsb_first_active
);
    input  wire       sys_clk;
    input  wire       sys_rst;
    input  wire       cs_n;
    input  wire       sclk;
    input  wire       sdio_in;
    output wire       sdio_out;
    output wire       sdio_oe_n;
    output wire       read_out_pin;
    output wire       read_out_oe_n;
    output wire [7:0] pds_active;
    output wire       soft_reset_active;
    output wire       lsb_first_active;

    // Transfer states, one-hot
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_INSTR = 4'h2;
    localparam [3:0] ST_DATA  = 4'h4;
    localparam [3:0] ST_HOLD  = 4'h8;

    reg  [3:0]              state_reg;
    reg  [3:0]              state_next;
    reg                     first_reg;
    reg  [7:0]              instr_hi_reg;
    reg                     rw_reg;
    reg                     stream_reg;
    reg  [1:0]              left_reg;
    reg  [`SPCR_ADDR_W-1:0] addr_reg;
    reg  [7:0]              port_cfg_reg;
    reg  [7:0]              rb_sel_reg;
    reg  [7:0]              pds_buf_reg;
    reg  [7:0]              pds_act_reg;
    reg                     tx_load;
    reg  [7:0]              tx_byte;
    reg  [15:0]             instr_word;
    wire [7:0]              rx_byte;
    wire                    rx_done;
    wire                    dout;
    wire                    lsb_first;
    wire                    dir_sel;
    wire                    soft_rst;
    wire                    reading;
    wire                    wr_en;
    wire [`SPCR_ADDR_W-1:0] addr_stepped;

    // Step the address the way the bit order asks
    function [`SPCR_ADDR_W-1:0] addr_step;
        input [`SPCR_ADDR_W-1:0] a;
        input                    up;
        begin
            if (up) begin
                addr_step = a + {{(`SPCR_ADDR_W-1){1'b0}}, 1'b1};
            end else begin
                addr_step = a - {{(`SPCR_ADDR_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // Readback value of one address
    function [7:0] rd_value;
        input [`SPCR_ADDR_W-1:0] a;
        input [7:0]              cfg;
        input [7:0]              rbs;
        input [7:0]              pbuf;
        input [7:0]              pact;
        begin
            case (a)
                `SPCR_ADDR_PORT_CFG: rd_value = cfg;
                `SPCR_ADDR_RB_SEL:   rd_value = rbs;
                `SPCR_ADDR_PDS:      rd_value = rbs[`SPCR_BIT_RB_ACTIVE] ? pact : pbuf;
                default:             rd_value = `SPCR_RST_ZERO;
            endcase
        end
    endfunction

    // Mode bits taken from port configuration
    assign dir_sel   = port_cfg_reg[`SPCR_BIT_DIR];
    assign lsb_first = port_cfg_reg[`SPCR_BIT_LSB_FIRST];
    assign soft_rst  = port_cfg_reg[`SPCR_BIT_SOFT_RST];

    // Read enable stays up after the last counted byte, until chip select rises
    assign reading      = ((state_reg == ST_DATA) | (state_reg == ST_HOLD)) & rw_reg & ~cs_n;
    assign wr_en        = (state_reg == ST_DATA) & rx_done & ~rw_reg;
    assign addr_stepped = addr_step(addr_reg, lsb_first);

    // Pin direction: shared data pin or separate output pin
    assign sdio_out      = dout;
    assign read_out_pin  = dout;
    assign sdio_oe_n     = ~(reading & ~dir_sel);
    assign read_out_oe_n = ~(reading & dir_sel);

    assign pds_active        = pds_act_reg;
    assign soft_reset_active = soft_rst;
    assign lsb_first_active  = lsb_first;

    spcr_serdes u_serdes (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .sclk      (sclk),
        .cs_n      (cs_n),
        .din       (sdio_in),
        .lsb_first (lsb_first),
        .tx_load   (tx_load),
        .tx_byte   (tx_byte),
        .rx_byte   (rx_byte),
        .rx_done   (rx_done),
        .dout      (dout)
    );

    // Instruction word in wire order, whatever the bit order
    always @* begin
        if (lsb_first) begin
            instr_word = {rx_byte, instr_hi_reg};
        end else begin
            instr_word = {instr_hi_reg, rx_byte};
        end
    end

    // Next transfer state and read data loading
    always @* begin
        state_next = state_reg;
        tx_load    = 1'b0;
        tx_byte    = `SPCR_RST_ZERO;
        case (state_reg)
            ST_IDLE: begin
                if (!cs_n) begin
                    state_next = ST_INSTR;
                end
            end
            ST_INSTR: begin
                if (rx_done && !first_reg) begin
                    state_next = ST_DATA;
                    tx_load    = instr_word[`SPCR_INSTR_RW];
                    tx_byte    = rd_value(instr_word[`SPCR_INSTR_ADDR], port_cfg_reg, rb_sel_reg,
                                          pds_buf_reg, pds_act_reg);
                end
            end
            ST_DATA: begin
                if (rx_done) begin
                    if (!stream_reg && left_reg == 2'h0) begin
                        state_next = ST_HOLD;
                    end else begin
                        tx_load = rw_reg;
                        tx_byte = rd_value(addr_stepped, port_cfg_reg, rb_sel_reg, pds_buf_reg, pds_act_reg);
                    end
                end
            end
            ST_HOLD: begin
                state_next = ST_HOLD;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (cs_n) begin
            state_next = ST_IDLE;
        end
    end

    // Transfer bookkeeping: instruction bytes, count, address
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            first_reg    <= 1'b1;
            instr_hi_reg <= `SPCR_RST_ZERO;
            rw_reg       <= 1'b0;
            stream_reg   <= 1'b0;
            left_reg     <= 2'h0;
            addr_reg     <= {`SPCR_ADDR_W{1'b0}};
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) begin
                first_reg <= 1'b1;
            end
            if (state_reg == ST_INSTR && rx_done) begin
                if (first_reg) begin
                    instr_hi_reg <= rx_byte;
                    first_reg    <= 1'b0;
                end else begin
                    rw_reg     <= instr_word[`SPCR_INSTR_RW];
                    stream_reg <= (instr_word[`SPCR_INSTR_LEN] == `SPCR_LEN_STREAM);
                    left_reg   <= instr_word[`SPCR_INSTR_LEN];
                    addr_reg   <= instr_word[`SPCR_INSTR_ADDR];
                end
            end
            if (state_reg == ST_DATA && rx_done) begin
                addr_reg <= addr_stepped;
                if (left_reg != 2'h0) begin
                    left_reg <= left_reg - 2'h1;
                end
            end
        end
    end

    // Register file: port configuration, readback select, buffered and active settings
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_cfg_reg <= `SPCR_RST_PORT_CFG;
            rb_sel_reg   <= `SPCR_RST_RB_SEL;
            pds_buf_reg  <= `SPCR_RST_PDS;
            pds_act_reg  <= `SPCR_RST_PDS;
        end else begin
            if (wr_en && addr_reg == `SPCR_ADDR_PORT_CFG) begin
                // Only the high nibble steers; the low nibble is its mirror
                port_cfg_reg <= {rx_byte[`SPCR_NIB_HI], rx_byte[4], rx_byte[5], rx_byte[6], rx_byte[7]};
            end
            if (soft_rst) begin
                // Held at defaults until the host clears the bit
                rb_sel_reg  <= `SPCR_RST_RB_SEL;
                pds_buf_reg <= `SPCR_RST_PDS;
                pds_act_reg <= `SPCR_RST_PDS;
            end else if (wr_en) begin
                case (addr_reg)
                    `SPCR_ADDR_RB_SEL: begin
                        rb_sel_reg <= rx_byte;
                    end
                    `SPCR_ADDR_PDS: begin
                        pds_buf_reg <= rx_byte;
                    end
                    `SPCR_ADDR_COMMIT: begin
                        // Commit bit is never stored, so it reads back as 0
                        if (rx_byte[`SPCR_BIT_COMMIT]) begin
                            pds_act_reg <= pds_buf_reg;
                        end
                    end
                    default: begin
                        pds_act_reg <= pds_act_reg;
                    end
                endcase
            end
        end
    end
endmodule

// >>> test/spcr_port_chk.sv
// Checker for the serial port block: pin enables, read phase, mode flags and commit timing.
// Assumes it is bound onto spcr_port and sees only that module's ports.
`timescale 1ns/1ps

module spcr_port_chk (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       cs_n,
    input wire       sclk,
    input wire       sdio_in,
    input wire       sdio_out,
    input wire       sdio_oe_n,
    input wire       read_out_pin,
    input wire       read_out_oe_n,
    input wire [7:0] pds_active,
    input wire       soft_reset_active,
    input wire       lsb_first_active
);
    reg       sclk_prev_reg;
    reg [4:0] rise_cnt_reg;
    reg [2:0] rise_age_reg;
    wire      rise_seen = sclk && !sclk_prev_reg;

    // Rising sclk edges in the frame, and cycles since the last one
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_reg <= 1'b0;
            rise_cnt_reg  <= 5'h00;
            rise_age_reg  <= 3'h7;
        end else begin
            sclk_prev_reg <= sclk;
            if (cs_n) rise_cnt_reg <= 5'h00;
            else if (rise_seen && rise_cnt_reg != 5'h1F) rise_cnt_reg <= rise_cnt_reg + 5'h01;
            if (rise_seen) rise_age_reg <= 3'h0;
            else if (rise_age_reg != 3'h7) rise_age_reg <= rise_age_reg + 3'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Read phase continuing inside the frame
    sequence s_shared_read;
        !sdio_oe_n ##1 !cs_n;
    endsequence
    sequence s_sep_read;
        !read_out_oe_n ##1 !cs_n;
    endsequence

    a_oe_exclusive: assert property (sdio_oe_n || read_out_oe_n)
        else $error("Both data pins enabled together");
    a_idle_float: assert property (cs_n |-> sdio_oe_n && read_out_oe_n)
        else $error("Data pin enabled outside a frame");
    a_shared_bit: assert property ((!(sdio_oe_n && read_out_oe_n) && sclk) |-> $stable(read_out_pin) && sdio_out == read_out_pin)
        else $error("Read bit moved while serial clock high");
    a_oe_after_instr: assert property ((!sdio_oe_n || !read_out_oe_n) |-> rise_cnt_reg >= 5'h10)
        else $error("Read enable before sixteen instruction bits");
    a_shared_hold: assert property (s_shared_read |-> !sdio_oe_n)
        else $error("Shared pin released during read");
    a_sep_hold: assert property (s_sep_read |-> !read_out_oe_n)
        else $error("Output pin released during read");
    a_soft_clear: assert property (soft_reset_active |=> pds_active == 8'h00)
        else $error("Active settings not held at default in soft reset");
    a_commit_time: assert property ($changed(pds_active) |-> rise_age_reg <= 3'h3)
        else $error("Active settings changed away from a byte end");
    a_lsb_frame: assert property ($changed(lsb_first_active) |-> $past(cs_n) == 1'b0)
        else $error("Bit order changed outside a frame");
    a_soft_frame: assert property ($changed(soft_reset_active) |-> $past(cs_n) == 1'b0)
        else $error("Soft reset changed outside a frame");
endmodule

bind spcr_port spcr_port_chk spcr_port_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .read_out_pin(read_out_pin), .read_out_oe_n(read_out_oe_n), .pds_active(pds_active),
    .soft_reset_active(soft_reset_active), .lsb_first_active(lsb_first_active));

// >>> test/spcr_host_model.sv
// Host controller model: frames with 16-bit instructions and data bytes in either bit order.
// Assumes the bench resolves both data pins into sdio_line and ro_line.
`timescale 1ns/1ps

module spcr_host_model (
    input  wire sys_clk,
    output reg  cs_n,
    output reg  sclk,
    output reg  sdio_drv,
    input  wire sdio_line,
    input  wire ro_line
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n     = 1'b1;
        sclk     = 1'b0;
        sdio_drv = 1'b0;
    end

    // Configuration byte: long instruction kept, low nibble mirrors high nibble
    function [7:0] cfg_byte(input d, input l, input s);
        cfg_byte = {d, l, s, 1'b1, 1'b1, s, l, d};
    endfunction

    // One sclk period; a released line toggles so a stale value cannot pass
    task bit_io(input b, input rel, input dir, output s);
        @(negedge sys_clk);
        sclk     = 1'b0;
        sdio_drv = rel ? ~sdio_drv : b;
        repeat (3) @(negedge sys_clk);
        s    = dir ? ro_line : sdio_line;
        sclk = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask

    // Whole frame: instruction, then len+1 bytes
    task xfer(input rd, input [1:0] len, input [12:0] addr, input lsb, input dir,
              input [23:0] wd, output [23:0] rdat);
        reg [15:0] instr;
        reg        s;
        integer    k;
        integer    j;
        instr = {rd, len, addr};
        rdat  = 24'h000000;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (k = 0; k < 16; k = k + 1)
            bit_io(lsb ? instr[k] : instr[15-k], 1'b0, dir, s);
        for (k = 0; k <= len; k = k + 1)
            for (j = 0; j < 8; j = j + 1) begin
                bit_io(wd[8*k + (lsb ? j : 7-j)], rd, dir, s);
                rdat[8*k + (lsb ? j : 7-j)] = s;
            end
        @(negedge sys_clk);
        sclk = 1'b0;
        repeat (3) @(negedge sys_clk);
        cs_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

// >>> test/test_serial_port_config_regs.sv
// Bench for the serial port block: random and corner-case frames through the host model.
// Assumes the host model paces sclk and chip select from the falling sys_clk edge.
`timescale 1ns/1ps
`include "spcr_regs.vh"
`define CHECK(got, exp) begin total_checks = total_checks + 1; if ((got) !== (exp)) begin \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); num_errors = num_errors + 1; end end

module test_serial_port_config_regs;
    reg         sys_clk;
    reg         sys_rst;
    wire        cs_n;
    wire        sclk;
    wire        host_sdio;
    wire        sdio_out;
    wire        sdio_oe_n;
    wire        read_out_pin;
    wire        read_out_oe_n;
    wire [7:0]  pds_active;
    wire        soft_reset_active;
    wire        lsb_first_active;
    wire        sdio_line;
    wire        ro_line;
    integer     num_errors;
    integer     total_checks;
    integer     i;
    reg         dir;
    reg         lsb;
    reg  [7:0]  val;
    reg  [7:0]  act;
    reg  [23:0] rdat;

    // Shared pin resolved; a floating output pin shows the inverse of its last bit
    assign sdio_line = sdio_oe_n ? host_sdio : sdio_out;
    assign ro_line   = read_out_pin ^ read_out_oe_n;

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    spcr_port spcr_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
        .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .read_out_pin(read_out_pin),
        .read_out_oe_n(read_out_oe_n), .pds_active(pds_active), .soft_reset_active(soft_reset_active),
        .lsb_first_active(lsb_first_active));
    spcr_host_model spcr_host_model_inst (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
        .sdio_drv(host_sdio), .sdio_line(sdio_line), .ro_line(ro_line));

    // Expected stored configuration byte
    function [7:0] exp_cfg(input d, input l, input s);
        exp_cfg = {d, l, s, 1'b1, 1'b1, s, l, d};
    endfunction
    // Start of a two-byte frame whose second byte lands on 0x230
    function [12:0] first_addr(input l);
        first_addr = l ? 13'h022F : `SPCR_ADDR_RSVD;
    endfunction

    task wr(input [12:0] addr, input [1:0] len, input [23:0] data);
        spcr_host_model_inst.xfer(1'b0, len, addr, lsb, dir, data, rdat);
    endtask
    task rd(input [12:0] addr, input [1:0] len);
        spcr_host_model_inst.xfer(1'b1, len, addr, lsb, dir, 24'h000000, rdat);
    endtask
    task set_cfg(input d, input l, input s);
        wr(`SPCR_ADDR_PORT_CFG, 2'h0, {16'h0000, spcr_host_model_inst.cfg_byte(d, l, s)});
        dir = d;
        lsb = l;
    endtask
    task conclude;
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        num_errors = 0;
        total_checks = 0;
        dir = 1'b0;
        lsb = 1'b0;
        act = 8'h00;
        sys_rst = 1'b1;
        void'($urandom(32'h963f));
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        rd(`SPCR_ADDR_PORT_CFG, 2'h0);
        `CHECK(rdat[7:0], `SPCR_RST_PORT_CFG)
        rd(`SPCR_ADDR_RB_SEL, 2'h0);
        `CHECK(rdat[7:0], 8'h00)
        // Every pin use and bit order
        for (i = 0; i < 4; i = i + 1) begin
            set_cfg(i[1], i[0], 1'b0);
            `CHECK(lsb_first_active, lsb)
            rd(`SPCR_ADDR_PORT_CFG, 2'h0);
            `CHECK(rdat[7:0], exp_cfg(dir, lsb, 1'b0))
            val = $urandom;
            wr(`SPCR_ADDR_PDS, 2'h0, {16'h0000, val});
            rd(`SPCR_ADDR_PDS, 2'h0);
            `CHECK(rdat[7:0], val)
            `CHECK(pds_active, act)
            wr(`SPCR_ADDR_RB_SEL, 2'h0, 24'h000001);
            rd(`SPCR_ADDR_PDS, 2'h0);
            `CHECK(rdat[7:0], act)
            wr(`SPCR_ADDR_COMMIT, 2'h0, 24'h000001);
            act = val;
            `CHECK(pds_active, act)
            rd(`SPCR_ADDR_COMMIT, 2'h0);
            `CHECK(rdat[7:0], 8'h00)
            rd(`SPCR_ADDR_PDS, 2'h0);
            `CHECK(rdat[7:0], act)
            wr(`SPCR_ADDR_RB_SEL, 2'h0, 24'h000000);
            // Address steps down or up across bytes
            val = $urandom;
            wr(first_addr(lsb), 2'h1, {8'h00, val, ~val});
            rd(`SPCR_ADDR_PDS, 2'h0);
            `CHECK(rdat[7:0], val)
            rd(first_addr(lsb), 2'h1);
            `CHECK(rdat[15:0], {val, 8'h00})
        end
        // Soft reset holds settings at default until written back
        set_cfg(dir, lsb, 1'b1);
        `CHECK(soft_reset_active, 1'b1)
        `CHECK(pds_active, 8'h00)
        wr(`SPCR_ADDR_PDS, 2'h0, 24'h00005A);
        rd(`SPCR_ADDR_PDS, 2'h0);
        `CHECK(rdat[7:0], 8'h00)
        `CHECK(soft_reset_active, 1'b1)
        set_cfg(dir, lsb, 1'b0);
        `CHECK(soft_reset_active, 1'b0)
        wr(`SPCR_ADDR_PDS, 2'h0, 24'h0000A5);
        rd(`SPCR_ADDR_PDS, 2'h0);
        `CHECK(rdat[7:0], 8'hA5)
        // Three-byte frames: middle byte lands on 0x230
        val = $urandom;
        wr(first_addr(lsb), 2'h2, {~val, val, 8'h00});
        rd(first_addr(lsb), 2'h2);
        `CHECK(rdat, {8'h00, val, 8'h00})
        rd(13'h0100, 2'h0);
        `CHECK(rdat[7:0], 8'h00)
        conclude;
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors = num_errors + 1;
        conclude;
    end
endmodule
